// File: hdl/ilc_pkg.sv
// Behaviour
// R1: select pin high: 500mA limit, type 001
// R2: select pin low: 3.25A limit, type 010
// R3: rerun bit starts detection, self-clears when done
// R4: absolute select 1: host writes floor directly
// R5: absolute select 0: algorithm owns read-only floor
// R6: alert pulse once floor threshold is set
// R7: floor setting spans 3.9 V to 14 V
// R8: converter switches only after limit is known
// R9: battery switch on only if charging enabled
// R10: rail below 2.2 V: min(200mA, programmed)
// R11: above 2.2 V: min(pin, programmed/optimizer result)
// R12: optimizer enable resets 1, clearing disables it
// R13: optimizer runs automatically after adapter detection
// R14: force-run bit runs optimizer for any source
// R15: effective limit register shows limit in use
// R16: pin clamps limit unless pin enable 0; code ignores the pin while the rail is below 2.2 V
// R17: pulse-skip when battery low or charging off
// R18: converter switches at fixed 1.5 MHz
// R19: host may request high impedance after 2 min
// R20: writing 0 to self-clearing bits does nothing
package ilc_pkg;
  // register offsets
  localparam logic [2:0] ADDR_CTRL     = 3'h0;
  localparam logic [2:0] ADDR_PROG_LIM = 3'h1;
  localparam logic [2:0] ADDR_FLOOR    = 3'h2;
  localparam logic [2:0] ADDR_OFFSET   = 3'h3;
  localparam logic [2:0] ADDR_STATUS   = 3'h4;
  localparam logic [2:0] ADDR_EFF_LIM  = 3'h5;
  // control bit positions
  localparam int BIT_RERUN    = 0;
  localparam int BIT_ABS      = 1;
  localparam int BIT_OPT_EN   = 2;
  localparam int BIT_OPT_FRC  = 3;
  localparam int BIT_PIN_EN   = 4;
  localparam int BIT_CHG_EN   = 5;
  localparam int BIT_HIZ      = 6;
  // control reset: optimizer, pin clamp and charging enabled
  localparam logic [7:0] CTRL_RST = 8'h34;
  // current codes: 100 mA base, 50 mA per step
  localparam logic [5:0] LIM_500MA  = 6'h08;
  localparam logic [5:0] LIM_3250MA = 6'h3F;
  localparam logic [5:0] LIM_200MA  = 6'h02;
  localparam logic [5:0] LIM_MIN    = 6'h00;
  // floor codes: 3.9 V base, 100 mV per step, 14 V top
  localparam logic [6:0] FLOOR_MAX  = 7'h65;
  localparam logic [6:0] FLOOR_RST  = 7'h0E;
  localparam logic [4:0] OFFSET_RST = 5'h06;
  // source type codes
  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_HOST    = 3'h1;
  localparam logic [2:0] SRC_ADAPTER = 3'h2;
  // timing
  localparam int CLK_MHZ       = 250;
  localparam int DETECT_US     = 10;
  localparam int DETECT_CYC    = DETECT_US * CLK_MHZ;
  localparam int STEP_US       = 1;
  localparam int STEP_CYC      = STEP_US * CLK_MHZ;
  localparam int SW_FREQ_KHZ   = 1500;
  localparam int SW_PERIOD_CYC = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
endpackage

// File: hdl/ilc_optimizer.sv
`timescale 1ns/1ns
// input current search: ramps the limit until the input sags or the ceiling is reached
module ilc_optimizer (
  // clock and reset
  input  wire logic       sysClk,
  input  wire logic       reset_n,
  // control
  input  wire logic       start,
  input  wire logic [5:0] ceiling,
  input  wire logic       floorHit,
  // result
  output logic            busy,
  output logic            done,
  output logic [5:0]      result
);
  import ilc_pkg::*;

  logic [7:0] stepCnt_reg;  // dwell per step

  // search: one code per step, stop on sag or at the ceiling
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      busy        <= 1'b0;
      done        <= 1'b0;
      result      <= LIM_500MA;
      stepCnt_reg <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        // restart from the floor so a weak source is never overloaded
        busy        <= 1'b1;
        result      <= LIM_MIN;
        stepCnt_reg <= 8'h00;
      end else if (busy) begin
        if (floorHit) begin
          // back off one step: the last code already sagged the input
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= (result == LIM_MIN) ? LIM_MIN : result - 6'h01;
        end else if (stepCnt_reg == 8'(STEP_CYC - 1)) begin
          stepCnt_reg <= 8'h00;
          if (result >= ceiling) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            result <= result + 6'h01;
          end
        end else begin
          stepCnt_reg <= stepCnt_reg + 8'h01;
        end
      end
    end
  end
endmodule

// File: hdl/ilc_input_limit_control.sv
`timescale 1ns/1ns
// input stage control: source detection, floor, start-up, limit
module ilc_input_limit_control (
  // clock and reset
  input  wire logic       sysClk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  // analog status pins
  input  wire logic       sourceSelectPin,
  input  wire logic [5:0] externalLimitPin,
  input  wire logic       sysRailHigh,
  input  wire logic       batteryBelowMin,
  input  wire logic       lightLoad,
  input  wire logic       floorHit,
  input  wire logic [6:0] busVoltageCode,
  // converter drive
  output logic            converterEnable,
  output logic            highSideSwitch,
  output logic            lowSideSwitch,
  output logic            batterySwitch,
  output logic            pulseSkipMode,
  output logic      [5:0] inputLimitCode,
  output logic            hostAlert
);
  import ilc_pkg::*;

  typedef enum {ST_IDLE, ST_DETECT, ST_RUN} ilc_state_type;

  // synchronisers: stage one feeds stage two only
  logic       selMeta, selSync;
  logic [5:0] pinMeta, pinSync;
  logic       railMeta, railSync;
  logic       batMeta, batSync;
  logic       loadMeta, loadSync;
  logic       hitMeta, hitSync;
  logic [6:0] busMeta, busSync;

  ilc_state_type state_reg;           // detection sequencer
  logic [11:0]   detCnt_reg;          // detection timer
  logic [7:0]    ctrl_reg;            // control bits
  logic [5:0]    progLim_reg;         // programmed input current limit
  logic [6:0]    floor_reg;           // input voltage floor
  logic [4:0]    offset_reg;          // floor offset setting
  logic [2:0]    srcType_reg;         // source type code
  logic          hostPort_reg;        // port flag, set by every detection whatever the source
  logic          limitKnown_reg;      // limit determined at least once
  logic [5:0]    effLim_reg;          // effective current limit
  logic [7:0]    pwmCnt_reg;          // switching period counter
  logic          detDone;             // detection finishing this cycle
  logic          optStart;            // optimizer launch request
  logic          optBusy, optDone;
  logic [5:0]    optResult;
  logic [5:0]    limNext;             // limit before registering
  logic [6:0]    floorCalc;           // algorithm floor
  logic          wrCtrl;

  // two-flop capture of every outside level
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      {selMeta, selSync}   <= 2'b00;
      {pinMeta, pinSync}   <= 12'h000;
      {railMeta, railSync} <= 2'b00;
      {batMeta, batSync}   <= 2'b00;
      {loadMeta, loadSync} <= 2'b00;
      {hitMeta, hitSync}   <= 2'b00;
      {busMeta, busSync}   <= 14'h0000;
    end else begin
      selMeta  <= sourceSelectPin;
      selSync  <= selMeta;
      pinMeta  <= externalLimitPin;
      pinSync  <= pinMeta;
      railMeta <= sysRailHigh;
      railSync <= railMeta;
      batMeta  <= batteryBelowMin;
      batSync  <= batMeta;
      loadMeta <= lightLoad;
      loadSync <= loadMeta;
      hitMeta  <= floorHit;
      hitSync  <= hitMeta;
      busMeta  <= busVoltageCode;
      busSync  <= busMeta;
    end
  end

  assign wrCtrl  = wrStb && (addr == ADDR_CTRL);
  assign detDone = (state_reg == ST_DETECT) && (detCnt_reg == 12'(DETECT_CYC - 1));

  // detection sequencer: runs at power-up and on rerun request
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      detCnt_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg  <= ST_DETECT;
          detCnt_reg <= 12'h000;
        end
        ST_DETECT: begin
          // pin sampled once the window ends, after it has settled
          if (detDone) begin
            state_reg <= ST_RUN;
          end else begin
            detCnt_reg <= detCnt_reg + 12'h001;
          end
        end
        ST_RUN: begin
          if (ctrl_reg[BIT_RERUN]) begin  // R3
            state_reg  <= ST_DETECT;
            detCnt_reg <= 12'h000;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // detection result fields
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      srcType_reg    <= SRC_NONE;
      hostPort_reg   <= 1'b0;
      limitKnown_reg <= 1'b0;
    end else if (detDone) begin
      srcType_reg    <= selSync ? SRC_HOST : SRC_ADAPTER;  // R1 R2
      hostPort_reg   <= 1'b1;
      limitKnown_reg <= 1'b1;
    end
  end

  // control bits; self-clearing bits only ever set by a one
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RST;  // R12
    end else begin
      if (wrCtrl) begin
        ctrl_reg[7:4]       <= wrData[7:4];
        ctrl_reg[BIT_ABS]   <= wrData[BIT_ABS];
        ctrl_reg[BIT_OPT_EN] <= wrData[BIT_OPT_EN];  // R12
      end
      // a zero write leaves a running detection alone
      if (wrCtrl && wrData[BIT_RERUN]) begin  // R20
        ctrl_reg[BIT_RERUN] <= 1'b1;
      end else if (detDone) begin
        ctrl_reg[BIT_RERUN] <= 1'b0;  // R3
      end
      // set wins over completion in the same cycle
      if (wrCtrl && wrData[BIT_OPT_FRC]) begin  // R20
        ctrl_reg[BIT_OPT_FRC] <= 1'b1;  // R14
      end else if (optDone) begin
        ctrl_reg[BIT_OPT_FRC] <= 1'b0;
      end
    end
  end

  // programmed limit: detection loads it, software may override
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      progLim_reg <= LIM_500MA;
    end else if (detDone) begin
      progLim_reg <= selSync ? LIM_500MA : LIM_3250MA;  // R1 R2
    end else if (wrStb && addr == ADDR_PROG_LIM) begin
      progLim_reg <= wrData[5:0];
    end
  end

  // algorithm floor: bus voltage less offset, held in range
  always_comb begin
    if ({2'b00, offset_reg} >= busSync) begin
      floorCalc = 7'h00;
    end else if (busSync - {2'b00, offset_reg} > FLOOR_MAX) begin
      floorCalc = FLOOR_MAX;  // R7
    end else begin
      floorCalc = busSync - {2'b00, offset_reg};
    end
  end

  // floor register, offset register and the alert pulse
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      floor_reg  <= FLOOR_RST;
      offset_reg <= OFFSET_RST;
      hostAlert  <= 1'b0;
    end else begin
      hostAlert <= 1'b0;
      if (wrStb && addr == ADDR_OFFSET) begin
        offset_reg <= wrData[4:0];
      end
      if (ctrl_reg[BIT_ABS]) begin
        // absolute mode: host value, clipped at the top code
        if (wrStb && addr == ADDR_FLOOR) begin  // R4
          floor_reg <= (wrData[6:0] > FLOOR_MAX) ? FLOOR_MAX : wrData[6:0];  // R7
          hostAlert <= 1'b1;  // R6
        end
      end else if (detDone) begin
        // host writes are dropped; only detection updates it
        floor_reg <= floorCalc;  // R5
        hostAlert <= 1'b1;  // R6
      end
    end
  end

  // auto run after adapter detection, or forced for any source
  assign optStart = (detDone && ctrl_reg[BIT_OPT_EN] && !selSync)  // R13
                  || (ctrl_reg[BIT_OPT_FRC] && !optBusy && !optDone);  // R14

  ilc_optimizer optimizer (
    .sysClk   (sysClk),
    .reset_n  (reset_n),
    .start    (optStart),
    .ceiling  (progLim_reg),
    .floorHit (hitSync),
    .busy     (optBusy),
    .done     (optDone),
    .result   (optResult)
  );

  // limit selection: soft-start cap, then pin clamp
  always_comb begin
    logic [5:0] base;
    base = 6'h00;
    if (!railSync) begin
      limNext = (progLim_reg < LIM_200MA) ? progLim_reg : LIM_200MA;  // R10
    end else begin
      base = ctrl_reg[BIT_OPT_EN] ? optResult : progLim_reg;  // R11
      if (ctrl_reg[BIT_PIN_EN] && pinSync < base) begin  // R16
        limNext = pinSync;
      end else begin
        limNext = base;
      end
    end
  end

  // limit in use, reported back to software
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      effLim_reg     <= LIM_MIN;
      inputLimitCode <= LIM_MIN;
    end else begin
      effLim_reg     <= limNext;  // R15
      inputLimitCode <= limNext;
    end
  end

  // converter enable and switch drive
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      converterEnable <= 1'b0;
      batterySwitch   <= 1'b0;
      pulseSkipMode   <= 1'b0;
    end else begin
      converterEnable <= limitKnown_reg && !ctrl_reg[BIT_HIZ];  // R8
      batterySwitch   <= limitKnown_reg && !ctrl_reg[BIT_HIZ] && ctrl_reg[BIT_CHG_EN];  // R9
      pulseSkipMode   <= batSync || !ctrl_reg[BIT_CHG_EN];  // R17
    end
  end

  // fixed period oscillator; one idle cycle after the high-side gate, none after the low-side gate
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      pwmCnt_reg     <= 8'h00;
      highSideSwitch <= 1'b0;
      lowSideSwitch  <= 1'b0;
    end else begin
      pwmCnt_reg <= (pwmCnt_reg == 8'(SW_PERIOD_CYC - 1)) ? 8'h00 : pwmCnt_reg + 8'h01;  // R18
      if (!converterEnable || (pulseSkipMode && loadSync)) begin
        // skipped pulses save switching loss at light load
        highSideSwitch <= 1'b0;
        lowSideSwitch  <= 1'b0;
      end else begin
        highSideSwitch <= pwmCnt_reg < 8'(SW_PERIOD_CYC / 2);  // R8
        lowSideSwitch  <= pwmCnt_reg > 8'(SW_PERIOD_CYC / 2);
      end
    end
  end

  // read port: data stands one cycle after the strobe only
  always_ff @(posedge sysClk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        ADDR_CTRL:     rdData <= ctrl_reg;
        ADDR_PROG_LIM: rdData <= {2'b00, progLim_reg};
        ADDR_FLOOR:    rdData <= {1'b0, floor_reg};
        ADDR_OFFSET:   rdData <= {3'b000, offset_reg};
        ADDR_STATUS:   rdData <= {optBusy, pulseSkipMode, converterEnable, hostPort_reg, 1'b0, srcType_reg};
        ADDR_EFF_LIM:  rdData <= {2'b00, effLim_reg};
        default:       rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

  // checks
  default clocking @(posedge sysClk); endclocking
  default disable iff (!reset_n);

  a_host_limit: assert property (detDone && selSync |=> progLim_reg == LIM_500MA && srcType_reg == SRC_HOST)  // R1
    else $error("host port limit or type wrong");
  a_adapter_limit: assert property (detDone && !selSync |=> progLim_reg == LIM_3250MA && srcType_reg == SRC_ADAPTER)  // R2
    else $error("adapter limit or type wrong");
  a_rerun_clear: assert property (detDone && !(wrCtrl && wrData[BIT_RERUN]) |=> !ctrl_reg[BIT_RERUN])  // R3
    else $error("rerun bit not cleared");
  a_floor_locked: assert property (!ctrl_reg[BIT_ABS] && !detDone |=> $stable(floor_reg))  // R5
    else $error("floor changed outside algorithm");
  a_alert_pulse: assert property (hostAlert |=> !hostAlert)  // R6
    else $error("alert longer than a pulse");
  a_floor_range: assert property (floor_reg <= FLOOR_MAX)  // R7
    else $error("floor out of range");
  a_switch_gate: assert property (!limitKnown_reg |-> !highSideSwitch && !lowSideSwitch)  // R8
    else $error("switching before limit known");
  a_soft_start: assert property (!railSync |=> effLim_reg <= LIM_200MA && effLim_reg <= $past(progLim_reg))  // R10
    else $error("soft start limit exceeded");
  a_pin_clamp: assert property (railSync && ctrl_reg[BIT_PIN_EN] |=> effLim_reg <= $past(pinSync))  // R16
    else $error("pin clamp ignored");
  a_skip_select: assert property (batSync |=> pulseSkipMode)  // R17
    else $error("pulse skip not selected");
  a_no_overlap: assert property (!(highSideSwitch && lowSideSwitch))  // R18
    else $error("both switches on");
  // a rerun request seen in the run state must restart the window
  a_rerun_start: assert property (state_reg == ST_RUN && ctrl_reg[BIT_RERUN] |=> state_reg == ST_DETECT)  // R3
    else $error("rerun did not restart detection");
  // a zero written over a pending rerun must not drop it
  a_zero_write: assert property (wrCtrl && ctrl_reg[BIT_RERUN] && !detDone |=> ctrl_reg[BIT_RERUN])  // R20
    else $error("zero write aborted detection");
  // in-range absolute writes land unchanged
  a_abs_write: assert property (ctrl_reg[BIT_ABS] && wrStb && addr == ADDR_FLOOR && wrData <= {1'b0, FLOOR_MAX}  // R4
    |=> {1'b0, floor_reg} == $past(wrData))
    else $error("absolute floor write lost");
  a_converter_gate: assert property (!limitKnown_reg |=> !converterEnable)  // R8
    else $error("converter on before limit known");
  a_battery_gate: assert property (!ctrl_reg[BIT_CHG_EN] |=> !batterySwitch)  // R9
    else $error("battery switch on with charging off");
  // with the optimizer off its stale result must not leak through
  a_opt_disabled: assert property (railSync && !ctrl_reg[BIT_OPT_EN] && !ctrl_reg[BIT_PIN_EN]  // R12
    |=> effLim_reg == $past(progLim_reg))
    else $error("optimizer result used while disabled");
  a_auto_search: assert property (detDone && ctrl_reg[BIT_OPT_EN] && !selSync && !optBusy |=> optBusy)  // R13
    else $error("search not started after adapter");
  a_forced_search: assert property (ctrl_reg[BIT_OPT_FRC] && !optBusy && !optDone |=> optBusy)  // R14
    else $error("forced search not started");
  a_skip_release: assert property (!batSync && ctrl_reg[BIT_CHG_EN] |=> !pulseSkipMode)  // R17
    else $error("pulse skip without cause");
  a_period_wrap: assert property (pwmCnt_reg == 8'(SW_PERIOD_CYC - 1) |=> pwmCnt_reg == 8'h00)  // R18
    else $error("switching period wrong");
endmodule

// File: test/ilc_phy_model.sv
`timescale 1ns/1ns
// stand-in for the usb phy and the input source
module ilc_phy_model (
  // clock
  input  wire logic       sysClk,
  // bench commands
  input  wire logic       hostPort,
  input  wire logic [5:0] limitCmd,
  input  wire logic [5:0] sagCode,
  // device side
  input  wire logic [5:0] inputLimitCode,
  output logic            sourceSelectPin,
  output logic      [5:0] externalLimitPin,
  output logic            floorHit
);
  // defined levels from time zero, phy starts as a host port
  initial begin
    sourceSelectPin  = 1'b1;
    externalLimitPin = 6'h3F;
    floorHit         = 1'b0;
  end
  // pins move only after an edge, like a real phy output
  always @(posedge sysClk) begin
    sourceSelectPin  <= hostPort;
    externalLimitPin <= limitCmd;
  end
  // source sags once the drawn limit reaches its capacity
  always @(posedge sysClk) begin
    floorHit <= (inputLimitCode >= sagCode);
  end
endmodule

// File: test/input_limit_selection_control_test.sv
`timescale 1ns/1ns
// self-checking bench for the input stage control
module input_limit_selection_control_test;
  import ilc_pkg::*;
  // clock, reset and register port
  logic        sysClk          = 1'b0;
  logic        reset_n         = 1'b0;
  logic [2:0]  addr            = 3'h0;
  logic [7:0]  wrData          = 8'h00;
  logic        wrStb           = 1'b0;
  logic        rdStb           = 1'b0;
  logic [7:0]  rdData;
  // analog environment driven by the bench
  logic        hostPort        = 1'b1;
  logic [5:0]  limitCmd        = 6'h3F;
  logic        sysRailHigh     = 1'b0;
  logic        batteryBelowMin = 1'b0;
  logic        lightLoad       = 1'b0;
  logic [6:0]  busVoltageCode  = 7'h30;
  // partner and converter outputs
  logic        sourceSelectPin, floorHit, converterEnable, highSideSwitch;
  logic        lowSideSwitch, batterySwitch, pulseSkipMode, hostAlert;
  logic [5:0]  externalLimitPin, inputLimitCode;
  // read notes: mask in the upper byte, expected value below
  logic [15:0] noteQ[$];
  logic [15:0] note;
  logic        rdPend          = 1'b0;
  logic [7:0]  lastRd;
  int          fails           = 0;
  int          cmpCount        = 0;

  always #2 sysClk = ~sysClk;

  ilc_input_limit_control i_dut (.sysClk(sysClk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .sourceSelectPin(sourceSelectPin),
    .externalLimitPin(externalLimitPin), .sysRailHigh(sysRailHigh), .batteryBelowMin(batteryBelowMin),
    .lightLoad(lightLoad), .floorHit(floorHit), .busVoltageCode(busVoltageCode),
    .converterEnable(converterEnable), .highSideSwitch(highSideSwitch), .lowSideSwitch(lowSideSwitch),
    .batterySwitch(batterySwitch), .pulseSkipMode(pulseSkipMode), .inputLimitCode(inputLimitCode),
    .hostAlert(hostAlert));

  // sag at a fixed capacity so the search ends early
  ilc_phy_model i_phy (.sysClk(sysClk), .hostPort(hostPort), .limitCmd(limitCmd), .sagCode(6'h0A),
    .inputLimitCode(inputLimitCode), .sourceSelectPin(sourceSelectPin),
    .externalLimitPin(externalLimitPin), .floorHit(floorHit));

  // masked compare of read data; case inequality keeps unknowns failing
  task automatic chkRead(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    cmpCount++;
    if ((got & mask) !== (exp & mask)) begin
      fails++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // compare of a pin or a measured count
  task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pin %h expected %h", $time, got, exp);
    end
  endtask

  // single-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sysClk);
    wrStb  <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge sysClk);
    wrStb  <= 1'b0;
  endtask

  // single-cycle read strobe; the monitor checks the answer
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge sysClk);
    rdStb <= 1'b1;
    addr  <= a;
    noteQ.push_back({mask, exp});
    @(posedge sysClk);
    rdStb <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sysClk) begin
    if (rdPend && noteQ.size() > 0) begin
      lastRd = rdData;
      note = noteQ.pop_front();
      chkRead(rdData, note[7:0], note[15:8]);
    end
    rdPend <= rdStb;
  end

  // poll a register until the masked bits drop, bounded
  task automatic waitClear(input logic [2:0] a, input logic [7:0] m);
    int i;
    for (i = 0; i < 8000; i++) begin
      rd(a, 8'h00, 8'h00);
      @(posedge sysClk);
      #1;
      if ((lastRd & m) === 8'h00) break;
    end
    chkPin(lastRd & m, 8'h00);
  endtask

  // alert is a one-cycle pulse, so look off the edge
  task automatic waitAlert();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge sysClk);
      #1;
      if (hostAlert === 1'b1) break;
    end
    chkPin(8'(hostAlert), 8'h01);
  endtask

  // cycles between two high-side turn-ons, 0 if it stays idle
  task automatic measure(output int cyc);
    int  i;
    int  st;
    bit  prev;
    cyc  = 0;
    st   = 0;
    prev = 1'b1;
    for (i = 0; i < 800 && st < 2; i++) begin
      @(posedge sysClk);
      #1;
      if (st > 0) cyc++;
      if (highSideSwitch === 1'b1 && !prev) st++;
      prev = (highSideSwitch === 1'b1);
    end
    if (st < 2) cyc = 0;
  endtask

  // verdict, reached from the sequence or the watchdog
  task automatic closeOut();
    if (fails == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: a generous margin over the full sequence
  initial begin
    #(4 * 90000);
    fails++;
    closeOut();
  end

  // main sequence
  initial begin
    int         per;
    logic [5:0] pin;
    logic [6:0] fl;
    void'($urandom(32'h26C6C407));
    @(posedge sysClk);
    busVoltageCode <= 7'h14 + 7'($urandom % 60);
    pin = 6'h01 + 6'($urandom % 7);
    repeat (11) @(posedge sysClk);
    reset_n <= 1'b1;
    fl = busVoltageCode - 7'(OFFSET_RST);
    // host port found at start-up
    rd(ADDR_CTRL, CTRL_RST, 8'hFF);
    repeat (100) @(posedge sysClk);
    #1;
    chkPin(8'(converterEnable), 8'h00);
    waitAlert();
    repeat (4) @(posedge sysClk);
    #1;
    chkPin(8'(converterEnable), 8'h01);
    chkPin(8'(inputLimitCode), 8'(LIM_200MA));
    rd(ADDR_PROG_LIM, 8'(LIM_500MA), 8'hFF);
    rd(ADDR_STATUS, 8'h30 | 8'(SRC_HOST), 8'hFF);
    rd(ADDR_FLOOR, 8'(fl), 8'hFF);
    wr(ADDR_FLOOR, 8'h00);
    rd(ADDR_FLOOR, 8'(fl), 8'hFF);
    measure(per);
    chkPin(8'(per), 8'(SW_PERIOD_CYC));
    // rail up, optimizer off, pin clamp on then off
    wr(ADDR_CTRL, 8'h30);
    sysRailHigh <= 1'b1;
    limitCmd    <= pin;
    repeat (8) @(posedge sysClk);
    #1;
    chkPin(8'(inputLimitCode), 8'(pin));
    rd(ADDR_EFF_LIM, 8'(pin), 8'hFF);
    wr(ADDR_CTRL, 8'h20);
    repeat (8) @(posedge sysClk);
    #1;
    chkPin(8'(inputLimitCode), 8'(LIM_500MA));
    // soft start below the 200 mA cap
    wr(ADDR_PROG_LIM, 8'h01);
    sysRailHigh <= 1'b0;
    repeat (8) @(posedge sysClk);
    #1;
    chkPin(8'(inputLimitCode), 8'h01);
    // charging off at light load: switch off, skipping
    wr(ADDR_CTRL, 8'h00);
    lightLoad <= 1'b1;
    repeat (8) @(posedge sysClk);
    #1;
    chkPin(8'(batterySwitch), 8'h00);
    chkPin(8'(pulseSkipMode), 8'h01);
    measure(per);
    chkPin(8'(per), 8'h00);
    chkPin(8'(lowSideSwitch), 8'h00);
    wr(ADDR_CTRL, 8'h20);
    batteryBelowMin <= 1'b1;
    repeat (8) @(posedge sysClk);
    #1;
    chkPin(8'(batterySwitch), 8'h01);
    chkPin(8'(pulseSkipMode), 8'h01);
    // host asks for high impedance, then lets go
    wr(ADDR_CTRL, 8'h60);
    batteryBelowMin <= 1'b0;
    lightLoad       <= 1'b0;
    repeat (4) @(posedge sysClk);
    #1;
    chkPin(8'(converterEnable), 8'h00);
    wr(ADDR_CTRL, 8'h20);
    hostPort <= 1'b0;
    // forced detection of an adapter; a zero write must not abort it
    wr(ADDR_CTRL, 8'h21);
    rd(ADDR_CTRL, 8'h21, 8'hFF);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h21, 8'hFF);
    waitAlert();
    repeat (4) @(posedge sysClk);
    rd(ADDR_CTRL, 8'h20, 8'hFF);
    rd(ADDR_PROG_LIM, 8'(LIM_3250MA), 8'hFF);
    rd(ADDR_STATUS, 8'h20 | 8'(SRC_ADAPTER), 8'h27);
    // adapter with optimizer on: search starts by itself
    wr(ADDR_CTRL, 8'h25);
    sysRailHigh <= 1'b1;
    waitAlert();
    repeat (3) @(posedge sysClk);
    rd(ADDR_STATUS, 8'h80, 8'h80);
    waitClear(ADDR_STATUS, 8'h80);
    // source sags at code 0x0A, so the search settles one below
    rd(ADDR_EFF_LIM, 8'h09, 8'hFF);
    // host port: no search unless forced
    @(posedge sysClk);
    hostPort <= 1'b1;
    wr(ADDR_CTRL, 8'h25);
    waitAlert();
    repeat (3) @(posedge sysClk);
    rd(ADDR_STATUS, 8'h01, 8'h87);
    wr(ADDR_CTRL, 8'h2C);
    rd(ADDR_STATUS, 8'h80, 8'h80);
    waitClear(ADDR_CTRL, 8'h08);
    // no sag below the host ceiling: search stops at the 500mA code
    rd(ADDR_EFF_LIM, 8'(LIM_500MA), 8'hFF);
    // absolute floor, clipped at the top of its range
    wr(ADDR_CTRL, 8'h22);
    wr(ADDR_FLOOR, 8'h30);
    rd(ADDR_FLOOR, 8'h30, 8'hFF);
    wr(ADDR_FLOOR, 8'h7F);
    rd(ADDR_FLOOR, 8'(FLOOR_MAX), 8'hFF);
    rd(3'h7, 8'h00, 8'hFF);
    repeat (4) @(posedge sysClk);
    closeOut();
  end
endmodule
